// ### imdj_consts.svh
// imdj_consts.svh: encodings, link register, shift base and stall counts for the execution slice
// assumes: included by bare name by the slice
`ifndef IMDJ_CONSTS_SVH
`define IMDJ_CONSTS_SVH
`define IMDJ_OP_SPECIAL 6'h00
`define IMDJ_OP_REGIMM 6'h01
`define IMDJ_OP_J 6'h02
`define IMDJ_OP_JUMP_ABSOLUTE_LINK 6'h03
`define IMDJ_OP_BEQ 6'h04
`define IMDJ_OP_BNE 6'h05
`define IMDJ_OP_BLEZ 6'h06
`define IMDJ_OP_BGTZ 6'h07
`define IMDJ_OP_BEQL 6'h14
`define IMDJ_OP_BNEL 6'h15
`define IMDJ_OP_BLEZL 6'h16
`define IMDJ_OP_BGTZL 6'h17
`define IMDJ_FN_JUMP_INDIRECT 6'h08
`define IMDJ_FN_JUMP_INDIRECT_LINK 6'h09
`define IMDJ_FN_MOVE_FROM_HIGH 6'h10
`define IMDJ_FN_MOVE_TO_HIGH 6'h11
`define IMDJ_FN_MOVE_FROM_LOW 6'h12
`define IMDJ_FN_MOVE_TO_LOW 6'h13
`define IMDJ_FN_MUL_WORD_SIGNED 6'h18
`define IMDJ_FN_MUL_WORD_UNSIGNED 6'h19
`define IMDJ_FN_DIV 6'h1a
`define IMDJ_FN_DIV_WORD_UNSIGNED 6'h1b
`define IMDJ_FN_MUL_DWORD_SIGNED 6'h1c
`define IMDJ_FN_MUL_DWORD_UNSIGNED 6'h1d
`define IMDJ_FN_DIV_DWORD_SIGNED 6'h1e
`define IMDJ_FN_DIV_DWORD_UNSIGNED 6'h1f
`define IMDJ_FN_DWORD_SRA_PLUS32 6'h3f
`define IMDJ_LINK_GPR 5'h1f
`define IMDJ_SRA32_BASE 7'h20
`define IMDJ_STALL_MUL_W 7'h05
`define IMDJ_STALL_DIV_W 7'h25
`define IMDJ_STALL_MUL_D 7'h08
`define IMDJ_STALL_DIV_D 7'h45
`define IMDJ_INSN_BYTES 64'h4
`endif

// ### imdj_exec.sv
// imdj_exec.sv: integer execution slice for multiply, divide, the result pair, jumps and branches
// assumes: fetch and the register file sit outside; operands arrive already read
// What this block does
// - shift-right-arithmetic by 32 plus amount, 64-bit result
// - word multiply, product into result pair
// - word divide, quotient low, remainder high
// - moves between result pair and general registers
// - doubleword multiply, 128-bit product across pair
// - doubleword divide, quotient low, remainder high
// - multiply or divide stalls the whole pipeline
// - word multiply 5, word divide 37 cycles
// - doubleword multiply 8, divide 69 cycles
// - every jump or branch has one delay slot
// - delay slot runs while target is fetched
// - absolute jump: target field under upper slot address bits
// - absolute linking jump writes return address to link_gpr
// - indirect jump goes to register address
// - indirect link writes return to named destination
// - branches use signed 16-bit pc-relative displacement
// - target is slot address plus displacement times four
// - likely branch not taken cancels delay slot
`timescale 1ns/1ps
`default_nettype none
`include "imdj_consts.svh"
module imdj_exec
  import imdj_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic mode64,
  input wire imdj_issue_t issue,
  output imdj_wb_t wb,
  output imdj_redirect_t redirect,
  output logic stall,
  output logic [63:0] result_high_reg,
  output logic [63:0] result_low_reg
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic [5:0] opc, fn;
  logic [4:0] src_reg_b_f, dest_f;
  logic [4:0] shift_amount;
  logic [15:0] disp;
  logic [25:0] tgt;
  assign opc = issue.insn[31:26];
  assign src_reg_b_f = issue.insn[20:16];
  assign dest_f = issue.insn[15:11];
  assign shift_amount = issue.insn[10:6];
  assign fn = issue.insn[5:0];
  assign disp = issue.insn[15:0];
  assign tgt = issue.insn[25:0];

  logic is_special;
  assign is_special = issue.valid && (opc == `IMDJ_OP_SPECIAL);

  // ------------------------------------------------------------
  // arithmetic
  // ------------------------------------------------------------
  logic [63:0] a, b, a32s, b32s, a32u, b32u;
  assign a = issue.src_a;
  assign b = issue.src_b;
  assign a32s = {{32{a[31]}}, a[31:0]};
  assign b32s = {{32{b[31]}}, b[31:0]};
  assign a32u = {32'h0, a[31:0]};
  assign b32u = {32'h0, b[31:0]};

  function automatic logic [63:0] ext32(input logic [31:0] v, input logic m64);
    ext32 = m64 ? {{32{v[31]}}, v} : {32'h0, v};
  endfunction

  // signed 128-bit multiply via magnitude to keep one multiplier shape
  function automatic logic [127:0] smul(input logic [63:0] x, input logic [63:0] y);
    logic [63:0] mx, my;
    logic [127:0] p;
    mx = x[63] ? (~x + 64'h1) : x;
    my = y[63] ? (~y + 64'h1) : y;
    p = {64'h0, mx} * {64'h0, my};
    smul = (x[63] ^ y[63]) ? (~p + 128'h1) : p;
  endfunction

  // truncating division; a zero divisor leaves an unspecified but defined pair
  function automatic logic [127:0] sdiv(input logic [63:0] x, input logic [63:0] y, input logic sgn);
    logic [63:0] mx, my, q, r;
    logic nx, ny;
    nx = sgn && x[63];
    ny = sgn && y[63];
    mx = nx ? (~x + 64'h1) : x;
    my = ny ? (~y + 64'h1) : y;
    q = (my == 64'h0) ? 64'hffffffffffffffff : mx / my;
    r = (my == 64'h0) ? mx : mx % my;
    if (nx ^ ny) q = ~q + 64'h1;
    if (nx) r = ~r + 64'h1;
    sdiv = {r, q};
  endfunction

  logic [127:0] mw_s, mw_u, md_s, md_u, dw_s, dw_u, dd_s, dd_u;
  assign mw_s = smul(a32s, b32s);
  assign mw_u = {64'h0, a32u} * {64'h0, b32u};
  assign md_s = smul(a, b);
  assign md_u = {64'h0, a} * {64'h0, b};
  assign dw_s = sdiv(a32s, b32s, 1'b1);
  assign dw_u = sdiv(a32u, b32u, 1'b0);
  assign dd_s = sdiv(a, b, 1'b1);
  assign dd_u = sdiv(a, b, 1'b0);

  // ------------------------------------------------------------
  // result pair, stall counter
  // ------------------------------------------------------------
  imdj_state_t state_r, state_nxt;
  logic [6:0] cnt_r, cnt_nxt;
  logic [63:0] res_high_r, res_high_nxt, res_low_r, res_low_nxt;
  logic [63:0] pend_high_r, pend_high_nxt, pend_low_r, pend_low_nxt;
  logic stall_r, stall_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    res_high_nxt = res_high_r;
    res_low_nxt = res_low_r;
    pend_high_nxt = pend_high_r;
    pend_low_nxt = pend_low_r;
    stall_nxt = stall_r;
    unique case (state_r)
      IMDJ_IDLE: begin
        if (is_special) begin
          unique case (fn)
            `IMDJ_FN_MOVE_TO_HIGH: res_high_nxt = a;
            `IMDJ_FN_MOVE_TO_LOW: res_low_nxt = a;
            `IMDJ_FN_MUL_WORD_SIGNED: begin
              pend_high_nxt = ext32(mw_s[63:32], mode64);
              pend_low_nxt = ext32(mw_s[31:0], mode64);
              cnt_nxt = `IMDJ_STALL_MUL_W;
            end
            `IMDJ_FN_MUL_WORD_UNSIGNED: begin
              pend_high_nxt = ext32(mw_u[63:32], mode64);
              pend_low_nxt = ext32(mw_u[31:0], mode64);
              cnt_nxt = `IMDJ_STALL_MUL_W;
            end
            `IMDJ_FN_DIV: begin
              pend_high_nxt = ext32(dw_s[95:64], mode64);
              pend_low_nxt = ext32(dw_s[31:0], mode64);
              cnt_nxt = `IMDJ_STALL_DIV_W;
            end
            `IMDJ_FN_DIV_WORD_UNSIGNED: begin
              pend_high_nxt = ext32(dw_u[95:64], mode64);
              pend_low_nxt = ext32(dw_u[31:0], mode64);
              cnt_nxt = `IMDJ_STALL_DIV_W;
            end
            `IMDJ_FN_MUL_DWORD_SIGNED: begin
              pend_high_nxt = md_s[127:64];
              pend_low_nxt = md_s[63:0];
              cnt_nxt = `IMDJ_STALL_MUL_D;
            end
            `IMDJ_FN_MUL_DWORD_UNSIGNED: begin
              pend_high_nxt = md_u[127:64];
              pend_low_nxt = md_u[63:0];
              cnt_nxt = `IMDJ_STALL_MUL_D;
            end
            `IMDJ_FN_DIV_DWORD_SIGNED: begin
              pend_high_nxt = dd_s[127:64];
              pend_low_nxt = dd_s[63:0];
              cnt_nxt = `IMDJ_STALL_DIV_D;
            end
            `IMDJ_FN_DIV_DWORD_UNSIGNED: begin
              pend_high_nxt = dd_u[127:64];
              pend_low_nxt = dd_u[63:0];
              cnt_nxt = `IMDJ_STALL_DIV_D;
            end
            default: ;
          endcase
          if (fn[5:3] == 3'b011) begin
            state_nxt = IMDJ_BUSY;
            stall_nxt = 1'b1;
          end
        end
      end
      IMDJ_BUSY: begin
        cnt_nxt = cnt_r - 7'h1;
        if (cnt_r == 7'h1) begin
          state_nxt = IMDJ_DONE;
          stall_nxt = 1'b0;
          res_high_nxt = pend_high_r;
          res_low_nxt = pend_low_r;
        end
      end
      IMDJ_DONE: state_nxt = IMDJ_IDLE;
      default: begin
        state_nxt = IMDJ_IDLE;
        stall_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= IMDJ_IDLE;
      cnt_r <= 7'h0;
      res_high_r <= 64'h0;
      res_low_r <= 64'h0;
      pend_high_r <= 64'h0;
      pend_low_r <= 64'h0;
      stall_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      res_high_r <= res_high_nxt;
      res_low_r <= res_low_nxt;
      pend_high_r <= pend_high_nxt;
      pend_low_r <= pend_low_nxt;
      stall_r <= stall_nxt;
    end
  end

  // ------------------------------------------------------------
  // write-back, jumps and branches
  // ------------------------------------------------------------
  imdj_wb_t wb_r, wb_nxt;
  imdj_redirect_t rd_r, rd_nxt;
  logic [63:0] slot_pc, ret_pc, br_tgt, sra_v;
  logic [6:0] sra_n;
  logic taken, likely, is_br, is_link_br;
  assign slot_pc = issue.pc + `IMDJ_INSN_BYTES;
  assign ret_pc = slot_pc + `IMDJ_INSN_BYTES;
  assign br_tgt = slot_pc + {{46{disp[15]}}, disp, 2'b00};
  assign sra_n = `IMDJ_SRA32_BASE + {2'b00, shift_amount};
  assign sra_v = 64'($signed(b) >>> sra_n);

  always_comb begin
    taken = 1'b0;
    likely = 1'b0;
    is_br = 1'b0;
    is_link_br = 1'b0;
    unique case (opc)
      `IMDJ_OP_BEQ, `IMDJ_OP_BEQL: begin
        is_br = 1'b1;
        taken = (a == b);
      end
      `IMDJ_OP_BNE, `IMDJ_OP_BNEL: begin
        is_br = 1'b1;
        taken = (a != b);
      end
      `IMDJ_OP_BLEZ, `IMDJ_OP_BLEZL: begin
        is_br = 1'b1;
        taken = a[63] || (a == 64'h0);
      end
      `IMDJ_OP_BGTZ, `IMDJ_OP_BGTZL: begin
        is_br = 1'b1;
        taken = !a[63] && (a != 64'h0);
      end
      `IMDJ_OP_REGIMM: begin
        is_br = 1'b1;
        taken = src_reg_b_f[0] ? !a[63] : a[63];
        likely = src_reg_b_f[1];
        is_link_br = src_reg_b_f[4];
      end
      default: ;
    endcase
    if (opc[5:2] == 4'b0101) likely = 1'b1;
  end

  always_comb begin
    wb_nxt = '0;
    rd_nxt = '0;
    if (issue.valid && !stall_r) begin
      if (opc == `IMDJ_OP_J || opc == `IMDJ_OP_JUMP_ABSOLUTE_LINK) begin
        rd_nxt.valid = 1'b1;
        rd_nxt.target = {slot_pc[63:28], tgt, 2'b00};
        if (opc == `IMDJ_OP_JUMP_ABSOLUTE_LINK) wb_nxt = '{1'b1, `IMDJ_LINK_GPR, ret_pc};
      end else if (is_special) begin
        unique case (fn)
          `IMDJ_FN_JUMP_INDIRECT: rd_nxt = '{1'b1, 1'b0, a};
          `IMDJ_FN_JUMP_INDIRECT_LINK: begin
            rd_nxt = '{1'b1, 1'b0, a};
            wb_nxt = '{1'b1, dest_f, ret_pc};
          end
          `IMDJ_FN_MOVE_FROM_HIGH: wb_nxt = '{1'b1, dest_f, res_high_r};
          `IMDJ_FN_MOVE_FROM_LOW: wb_nxt = '{1'b1, dest_f, res_low_r};
          `IMDJ_FN_DWORD_SRA_PLUS32: wb_nxt = '{1'b1, dest_f, sra_v};
          default: ;
        endcase
      end else if (is_br) begin
        // delay slot runs unless a likely branch is not taken, target fetched alongside
        rd_nxt.valid = taken;
        rd_nxt.target = br_tgt;
        rd_nxt.cancel_slot = likely && !taken;
        if (is_link_br) wb_nxt = '{1'b1, `IMDJ_LINK_GPR, ret_pc};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wb_r <= '0;
      rd_r <= '0;
    end else begin
      wb_r <= wb_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign wb = wb_r;
  assign redirect = rd_r;
  assign stall = stall_r;
  assign result_high_reg = res_high_r;
  assign result_low_reg = res_low_r;
endmodule
`default_nettype wire

// ### imdj_exec_assertions.sv
// imdj_exec_assertions.sv: port-level checker for the execution slice
// assumes: bound to imdj_exec; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module imdj_exec_chk
  import imdj_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire imdj_issue_t issue,
  input wire imdj_wb_t wb,
  input wire imdj_redirect_t redirect,
  input wire logic stall
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic [6:0] cnt_r, cnt_nxt, exp_r, exp_nxt;
  logic stq_r, stq_nxt, take, md;
  logic [5:0] op;
  logic [63:0] slot_pc, br_tgt;
  assign op = issue.insn[31:26];
  assign take = issue.valid && !stall;
  // mul/div is refused in the cycle right after a stall ends
  assign md = take && !stq_r && op == 6'h00 && issue.insn[5:3] == 3'b011;
  assign slot_pc = issue.pc + 64'h4;
  assign br_tgt = slot_pc + {{46{issue.insn[15]}}, issue.insn[15:0], 2'b00};
  always_comb begin
    cnt_nxt = stall ? cnt_r + 7'h01 : 7'h00;
    stq_nxt = stall;
    exp_nxt = exp_r;
    if (md) begin
      exp_nxt = issue.insn[2] ? (issue.insn[1] ? 7'h45 : 7'h08) : (issue.insn[1] ? 7'h25 : 7'h05);
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= 7'h00;
      exp_r <= 7'h00;
      stq_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
      stq_r <= stq_nxt;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_md_stalls: assert property (md |=> stall)
    else $error("stall did not follow a mul/div");
  chk_mulw_stall: assert property (md && issue.insn[2:1] == 2'b00 |=> stall[*5] ##1 !stall)
    else $error("word multiply stall length wrong");
  chk_stall_count: assert property ($fell(stall) |-> cnt_r == exp_r)
    else $error("stall length wrong for operation");
  chk_sra_result: assert property (take && op == 6'h00 && issue.insn[5:0] == 6'h3f |=> wb.valid
    && wb.dest == $past(issue.insn[15:11])
    && wb.data == 64'($signed($past(issue.src_b)) >>> (7'h20 + $past(issue.insn[10:6]))))
    else $error("shift plus 32 result wrong");
  chk_jump_target: assert property (take && op[5:1] == 5'b00001 |=> redirect.valid
    && redirect.target == {$past(slot_pc[63:28]), $past(issue.insn[25:0]), 2'b00})
    else $error("absolute jump target wrong");
  chk_jal_link: assert property (take && op == 6'h03 |=> wb.valid && wb.dest == 5'h1f
    && wb.data == $past(issue.pc) + 64'h8)
    else $error("jump link write wrong");
  chk_jr_target: assert property (take && op == 6'h00 && issue.insn[5:1] == 5'b00100
    |=> redirect.valid && redirect.target == $past(issue.src_a))
    else $error("indirect jump target wrong");
  chk_br_target: assert property (take && op == 6'h04 && issue.src_a == issue.src_b |=> redirect.valid
    && !redirect.cancel_slot && redirect.target == $past(br_tgt))
    else $error("branch target wrong");
  chk_likely_cancel: assert property (take && op == 6'h14 && issue.src_a != issue.src_b
    |=> redirect.cancel_slot && !redirect.valid)
    else $error("likely branch slot not cancelled");
endmodule
bind imdj_exec imdj_exec_chk u_chk (.clk(clk), .reset(reset), .issue(issue), .wb(wb), .redirect(redirect),
  .stall(stall));
`default_nettype wire

// ### imdj_exec_test.sv
// imdj_exec_test.sv: self-checking bench for the execution slice
// assumes: package, header and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module imdj_exec_test
  import imdj_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic mode64 = 1'b1;
  imdj_issue_t issue = '0;
  imdj_wb_t wb;
  imdj_redirect_t redirect;
  logic stall;
  logic [63:0] res_high, res_low;
  int num_errors = 0;
  int n_tests = 0;
  int st[8] = '{5, 5, 37, 37, 8, 8, 69, 69};
  always #5 clk = ~clk;
  imdj_exec u_dut (.clk(clk), .reset(reset), .mode64(mode64), .issue(issue), .wb(wb), .redirect(redirect),
    .stall(stall), .result_high_reg(res_high), .result_low_reg(res_low));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic go(input logic [31:0] insn, input logic [63:0] pc, a, b);
    // an idle edge first, so valid is never lowered and raised in one step
    @(negedge clk);
    issue = '{1'b1, insn, pc, a, b};
    @(negedge clk);
    issue.valid = 1'b0;
  endtask
  function automatic logic [127:0] ref_pair(input logic [5:0] f, input logic [63:0] a, b, input bit m);
    logic signed [127:0] w;
    case (f)
      6'h18: w = $signed(a[31:0]) * $signed(b[31:0]);
      6'h19: w = a[31:0] * b[31:0];
      6'h1a: w = {$signed(a[31:0]) % $signed(b[31:0]), $signed(a[31:0]) / $signed(b[31:0])};
      6'h1b: w = {a[31:0] % b[31:0], a[31:0] / b[31:0]};
      6'h1c: w = $signed(a) * $signed(b);
      6'h1d: w = a * b;
      6'h1e: w = {$signed(a) % $signed(b), $signed(a) / $signed(b)};
      default: w = {a % b, a / b};
    endcase
    if (f[2]) return w;
    // word results: each half widened per mode
    return m ? {{32{w[63]}}, w[63:32], {32{w[31]}}, w[31:0]} : {32'h0, w[63:32], 32'h0, w[31:0]};
  endfunction
  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_muldiv(input bit m);
    logic [127:0] ex;
    logic [63:0] a, b;
    int n;
    a = 64'h8000_0000_ffff_fff3;
    b = 64'h0000_0003_0000_0004;
    mode64 = m;
    for (int i = 0; i < 8; i++) begin
      ex = ref_pair(6'(8'h18 + i), a, b, m);
      go({16'h0022, 10'h0, 6'(8'h18 + i)}, 64'h0, a, b);
      n = 0;
      while (stall === 1'b1 && n < 100) begin
        n++;
        @(negedge clk);
      end
      `CHK("stall", st[i], n)
      `CHK("high", ex[127:64], res_high)
      `CHK("low", ex[63:0], res_low)
      @(negedge clk);
    end
    mode64 = 1'b1;
  endtask
  task automatic t_moves();
    go({6'h0, 5'd4, 15'h0, 6'h11}, 64'h0, 64'h1234_5678_9abc_def0, 64'h0);
    @(negedge clk);
    `CHK("high", 64'h1234_5678_9abc_def0, res_high)
    go({6'h0, 5'd4, 15'h0, 6'h13}, 64'h0, 64'h0fed_cba9_8765_4321, 64'h0);
    @(negedge clk);
    `CHK("low", 64'h0fed_cba9_8765_4321, res_low)
    go({16'h0, 5'd9, 5'h0, 6'h10}, 64'h0, 64'h0, 64'h0);
    `CHK("from_high", {1'b1, 5'd9, 64'h1234_5678_9abc_def0}, wb)
    go({16'h0, 5'd10, 5'h0, 6'h12}, 64'h0, 64'h0, 64'h0);
    `CHK("from_low", {1'b1, 5'd10, 64'h0fed_cba9_8765_4321}, wb)
  endtask
  task automatic t_sra();
    logic signed [63:0] v;
    logic [63:0] e;
    v = 64'hf234_5678_0000_0000;
    for (int s = 0; s < 32; s += 31) begin
      go({11'h0, 5'd2, 5'd3, 5'(s), 6'h3f}, 64'h0, 64'h0, v);
      // worked out apart, so an unsigned comparison cannot turn the shift logical
      e = v >>> (32 + s);
      `CHK("sra", e, wb.data)
    end
  endtask
  task automatic t_jumps();
    logic [63:0] pc;
    // slot address crosses a 256 MB boundary, so the upper bits differ
    pc = 64'h0000_0000_8fff_fffc;
    for (int k = 2; k < 4; k++) begin
      go({6'(k), 26'h0abcdef}, pc, 64'h0, 64'h0);
      `CHK("jtgt", {2'b10, 36'h9, 26'h0abcdef, 2'b00}, redirect)
    end
    `CHK("abs_link", {1'b1, 5'h1f, pc + 64'h8}, wb)
    go({6'h0, 5'd5, 5'h0, 5'd7, 5'h0, 6'h09}, pc, 64'h0000_0040_0000_1238, 64'h0);
    `CHK("ind_tgt", {2'b10, 64'h0000_0040_0000_1238}, redirect)
    `CHK("ind_link", {1'b1, 5'd7, pc + 64'h8}, wb)
    go({6'h0, 5'd6, 15'h0, 6'h08}, pc, 64'h0000_0000_0000_2000, 64'h0);
    `CHK("ind_only", {2'b10, 64'h0000_0000_0000_2000}, redirect)
    `CHK("ind_no_wb", 1'b0, wb.valid)
  endtask
  task automatic t_branch();
    logic [63:0] pc;
    pc = 64'h0000_0000_0000_1000;
    go({6'h04, 5'd1, 5'd2, 16'hfffe}, pc, 64'h5, 64'h5);
    `CHK("beq", {2'b10, pc - 64'h4}, redirect)
    go({6'h14, 5'd1, 5'd2, 16'h0010}, pc, 64'h5, 64'h6);
    `CHK("beql", 2'b01, redirect[65:64])
    go({6'h01, 5'd1, 5'h10, 16'h0003}, pc, 64'hffff_ffff_ffff_ffff, 64'h0);
    `CHK("bal", {1'b1, 5'h1f, pc + 64'h8}, wb)
    `CHK("baltgt", {2'b10, pc + 64'h10}, redirect)
  endtask
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    t_muldiv(1'b1);
    t_muldiv(1'b0);
    t_moves();
    t_sra();
    t_jumps();
    t_branch();
    tally_and_finish();
  end
  initial begin
    #50000;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### imdj_pkg.sv
// imdj_pkg.sv: types shared by the execution slice
// assumes: constants come from imdj_consts.svh
package imdj_pkg;
  typedef struct packed {
    logic valid;
    logic [31:0] insn;
    logic [63:0] pc;
    logic [63:0] src_a;
    logic [63:0] src_b;
  } imdj_issue_t;
  typedef struct packed {
    logic valid;
    logic [4:0] dest;
    logic [63:0] data;
  } imdj_wb_t;
  typedef struct packed {
    logic valid;
    logic cancel_slot;
    logic [63:0] target;
  } imdj_redirect_t;
  typedef enum logic [1:0] {
    IMDJ_IDLE = 2'b00,
    IMDJ_BUSY = 2'b01,
    IMDJ_DONE = 2'b11
  } imdj_state_t;
endpackage
